// ---- verilog/act_defines.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the
//          conversion timing block
// Assumes: included by bare name from every file that needs it
// Notes:   definitions only
`ifndef ACT_DEFINES_SVH
`define ACT_DEFINES_SVH

// Register byte offsets
`define ACT_OFF_CTL1    8'h00
`define ACT_OFF_CTL2    8'h04
`define ACT_OFF_INTDLY  8'h08
`define ACT_OFF_STAT    8'h0c
`define ACT_OFF_MASK    8'h10
`define ACT_OFF_FORCE   8'h14
`define ACT_OFF_STATUS  8'h18
`define ACT_OFF_INTSEL  8'h1c
// Upper address bits of the per-slot window and result banks
`define ACT_BANK_WIN    2'h1
`define ACT_BANK_RES    2'h2

// Field positions of converter_control_one
`define ACT_CTL1_IEOC   0
`define ACT_CTL1_DMA    1
`define ACT_CTL1_SCR    2
// Field positions of the sticky status and mask registers
`define ACT_ST_CINT     0
`define ACT_ST_LAT      1

// Reset values
`define ACT_CTL2_RST    4'h0
`define ACT_STAT_RST    2'h0
`define ACT_RES_RST     12'h000

// Timing counts in system clock cycles, plus the divider codes they depend on
`define ACT_EOC_BASE0   10'h00f
`define ACT_EOC_BASE1   10'h00e
`define ACT_LAT_GAP     10'h005
`define ACT_LAT_QCODE   4'h3
`define ACT_LAT_QUIRK   10'h003
`define ACT_RATIO_CODE  4'h2
`define ACT_RATIO_MIN   10'h002

`endif

// ---- verilog/act_pkg.sv ----
// Purpose: shared types of the conversion timing block
// Assumes: nothing
// Notes:   numbers live in act_defines.svh
package act_pkg;
	typedef logic [3:0] act_slot_t;
	typedef enum logic [1:0] {
		ACT_IDLE     = 2'b00,
		ACT_SAMPLE   = 2'b01,
		ACT_WAIT_EOC = 2'b10
	} act_state_t;
endpackage

// ---- verilog/act_tmr_if.sv ----
// Purpose: start, load and done of one delay timer
// Assumes: all signals on the system clock
// Notes:   done is combinational inside the timer
`timescale 1ns/100ps
interface act_tmr_if #(parameter int W = 9);
	logic         start;
	logic [W-1:0] load;
	logic         done;
	modport ctl (output start, output load, input done);
	modport tmr (input start, input load, output done);
endinterface

// ---- verilog/act_dly_timer.sv ----
// Purpose: one-shot delay, done rises load+1 cycles after the start cycle
// Assumes: start is a one-cycle pulse on clk
// Notes:   a start while running restarts the count
`timescale 1ns/100ps
module act_dly_timer #(parameter int W = 9) (
	input wire logic clk,
	input wire logic rst,
	act_tmr_if.tmr   t
);
	logic [W-1:0] cnt_r;
	logic         run_r;

	// Count down to zero, then fall idle
	always_ff @(posedge clk) begin
		if (rst) begin
			run_r <= 1'b0;
			cnt_r <= '0;
		end else if (t.start) begin
			run_r <= 1'b1;
			cnt_r <= t.load;
		end else if (run_r) begin
			if (cnt_r == '0) begin
				run_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	assign t.done = run_r && (cnt_r == '0);
endmodule

// ---- verilog/act_conv_timing.sv ----
// Purpose: sequencing and timing of sample windows, result latch,
//          end of conversion, interrupt flag and DMA trigger
// Assumes: CONV_DATA comes from the converter core on CORE_CLK
// Notes:   registers on a strobe port; read data stand one cycle late
// Behaviour
// - Sample window stays open programmed count plus one clock cycles.
// - Every slot keeps its own sample window count.
// - Result read before latch time returns the earlier conversion value.
// - Next window may start once end-of-conversion delay has passed.
// - With interrupt at conversion end set, flag rises with end of conversion.
// - Otherwise, with zero delay, flag rises one cycle after window end.
// - Otherwise a nonzero delay field postpones the flag by that many cycles.
// - DMA trigger at latch time when selected, else with the flag.
// - Without cap reset, delays 15/20 at code 0 up to 128/133.
// - With cap reset, 14/19 at code 0 up to 119/124; half steps.
// - Sixteen slots, each with its own addressable result register.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "act_defines.svh"
module act_conv_timing #(
	parameter int WIN_W = 9,
	parameter int DLY_W = 8
) (
	input  wire logic              CORE_CLK,
	input  wire logic              SYS_RST,
	input  wire logic [7:0]        REG_ADDR,
	input  wire logic [31:0]       REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic [31:0]            REG_RDATA,
	input  wire logic [11:0]       CONV_DATA,
	output logic                   SH_OPEN,
	output logic                   EOC_PULSE,
	output logic                   INT_EVENT,
	output logic                   DMA_TRIG,
	output logic                   CONV_IRQ,
	output logic                   BUSY,
	output act_pkg::act_slot_t     CUR_SLOT
);
	import act_pkg::*;

	localparam int TMR_W = DLY_W + 1;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic                ieoc_r;
	logic                dma_sel_r;
	logic                scr_r;
	logic [3:0]          presc_r;
	logic [DLY_W-1:0]    int_off_r;
	logic [1:0]          stat_r;
	logic [1:0]          mask_r;
	act_slot_t           int_src_r;
	logic [15:0]         pend_r;
	logic [WIN_W-1:0]    win_r [16];
	logic [11:0]         res_r [16];
	act_state_t          st_r;
	logic [WIN_W-1:0]    sh_cnt_r;
	act_slot_t           cur_r;
	act_slot_t           rr_r;
	act_slot_t           eoc_slot_r;
	act_slot_t           lat_slot_r [2];
	logic                lat_pp_r;
	logic [31:0]         rdata_r;
	logic                sh_open_r;
	logic                eoc_pulse_r;
	logic                int_evt_r;
	logic                dma_r;
	logic                irq_r;
	logic                busy_r;
	act_slot_t           slot_out_r;
	logic                is_win;
	logic                is_res;
	act_slot_t           rslot;
	logic                stat_wr;
	logic                force_wr;
	logic                pick_ok;
	act_slot_t           pick_slot;
	logic                start_now;
	logic                win_end;
	logic                eoc_done;
	logic [1:0]          lat_done;
	logic                lat_src;
	logic                cint_set;
	logic                dma_now;
	logic [1:0]          stat_nxt;
	logic [15:0]         pend_nxt;
	logic [9:0]          h2_w;
	logic [9:0]          eoc_w;
	logic [9:0]          lat_w;
	logic [31:0]         rd_mux;
	logic [11:0]         rd_res_w;

	act_tmr_if #(.W(TMR_W)) tmr_if [4] ();

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	assign is_win   = (REG_ADDR[7:6] == `ACT_BANK_WIN);
	assign is_res   = (REG_ADDR[7:6] == `ACT_BANK_RES);
	assign rslot    = REG_ADDR[5:2];
	assign stat_wr  = REG_WR && (REG_ADDR == `ACT_OFF_STAT);
	assign force_wr = REG_WR && (REG_ADDR == `ACT_OFF_FORCE);
	assign rd_res_w = res_r[rslot];

	// Control registers written by software
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ieoc_r    <= 1'b0;
			dma_sel_r <= 1'b0;
			scr_r     <= 1'b0;
			presc_r   <= `ACT_CTL2_RST;
			int_off_r <= '0;
			mask_r    <= `ACT_STAT_RST;
			int_src_r <= '0;
		end else if (REG_WR) begin
			unique case (REG_ADDR)
				`ACT_OFF_CTL1: begin
					ieoc_r    <= REG_WDATA[`ACT_CTL1_IEOC];
					dma_sel_r <= REG_WDATA[`ACT_CTL1_DMA];
					scr_r     <= REG_WDATA[`ACT_CTL1_SCR];
				end
				`ACT_OFF_CTL2:   presc_r   <= REG_WDATA[3:0];
				`ACT_OFF_INTDLY: int_off_r <= REG_WDATA[DLY_W-1:0];
				`ACT_OFF_MASK:   mask_r    <= REG_WDATA[1:0];
				`ACT_OFF_INTSEL: int_src_r <= REG_WDATA[3:0];
				default: ;
			endcase
		end
	end

	// One window count per slot, so slots may sample for different lengths
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < 16; i++) begin
				win_r[i] <= '0;
			end
		end else if (REG_WR && is_win) begin
			win_r[rslot] <= REG_WDATA[WIN_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Delay table: twice the prescale ratio, codes 0 and 1 both run at ratio 1
	always_comb begin
		h2_w = `ACT_RATIO_MIN;
		if (presc_r >= `ACT_RATIO_CODE) begin
			h2_w = {6'h00, presc_r} + `ACT_RATIO_MIN;
		end
		// Half-cycle ratios round the end-of-conversion count up
		eoc_w = (((scr_r ? `ACT_EOC_BASE1 : `ACT_EOC_BASE0) * h2_w) + 10'h001) >> 1;
		lat_w = eoc_w + `ACT_LAT_GAP;
		// Ratio 2.5 without cap reset latches three cycles later than the rest
		if (!scr_r && (presc_r == `ACT_LAT_QCODE)) begin
			lat_w = eoc_w + `ACT_LAT_GAP + `ACT_LAT_QUIRK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pending slots and round-robin pick
	always_comb begin
		pick_ok   = 1'b0;
		pick_slot = rr_r;
		for (int i = 0; i < 16; i++) begin
			if (!pick_ok && pend_r[4'(rr_r + 4'(i))]) begin
				pick_ok   = 1'b1;
				pick_slot = 4'(rr_r + 4'(i));
			end
		end
	end

	assign start_now = pick_ok && ((st_r == ACT_IDLE) || ((st_r == ACT_WAIT_EOC) && eoc_done));
	assign win_end   = (st_r == ACT_SAMPLE) && (sh_cnt_r == '0);

	// A force that lands on the slot being taken stays pending
	always_comb begin
		pend_nxt = pend_r;
		if (start_now) begin
			pend_nxt[pick_slot] = 1'b0;
		end
		if (force_wr) begin
			pend_nxt = pend_nxt | REG_WDATA[15:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			pend_r <= '0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: sample window, then wait for end of conversion
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			st_r      <= ACT_IDLE;
			sh_cnt_r  <= '0;
			cur_r     <= '0;
			rr_r      <= '0;
			sh_open_r <= 1'b0;
		end else begin
			unique case (st_r)
				ACT_SAMPLE: begin
					if (sh_cnt_r == '0) begin
						st_r      <= ACT_WAIT_EOC;
						sh_open_r <= 1'b0;
					end else begin
						sh_cnt_r <= sh_cnt_r - 1'b1;
					end
				end
				ACT_IDLE, ACT_WAIT_EOC: begin
					// The previous result need not be latched yet
					if (start_now) begin
						st_r      <= ACT_SAMPLE;
						sh_cnt_r  <= win_r[pick_slot];
						cur_r     <= pick_slot;
						rr_r      <= 4'(pick_slot + 4'h1);
						sh_open_r <= 1'b1;
					end else if (eoc_done || (st_r == ACT_IDLE)) begin
						st_r <= ACT_IDLE;
					end
				end
				default: st_r <= ACT_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timers: 0 end of conversion, 1 delayed flag, 2 and 3 latch ping-pong.
	// Two latch lanes because a short window can end before the last latch.
	for (genvar g = 0; g < 4; g++) begin : g_tmr
		act_dly_timer #(.W(TMR_W)) u_tmr (
			.clk (CORE_CLK),
			.rst (SYS_RST),
			.t   (tmr_if[g])
		);
	end

	assign tmr_if[0].start = win_end;
	assign tmr_if[0].load  = TMR_W'(eoc_w - 10'h001);
	assign tmr_if[1].start = win_end && !ieoc_r && (cur_r == int_src_r);
	assign tmr_if[1].load  = TMR_W'(int_off_r);
	assign tmr_if[2].start = win_end && !lat_pp_r;
	assign tmr_if[2].load  = TMR_W'(lat_w - 10'h001);
	assign tmr_if[3].start = win_end && lat_pp_r;
	assign tmr_if[3].load  = TMR_W'(lat_w - 10'h001);

	assign eoc_done    = tmr_if[0].done;
	assign lat_done[0] = tmr_if[2].done;
	assign lat_done[1] = tmr_if[3].done;

	// Remember which slot the end-of-conversion and latch delays belong to
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			eoc_slot_r    <= '0;
			lat_slot_r[0] <= '0;
			lat_slot_r[1] <= '0;
			lat_pp_r      <= 1'b0;
		end else if (win_end) begin
			eoc_slot_r           <= cur_r;
			lat_slot_r[lat_pp_r] <= cur_r;
			lat_pp_r             <= !lat_pp_r;
		end
	end

	// Results change only at latch time, so earlier reads see the old value
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < 16; i++) begin
				res_r[i] <= `ACT_RES_RST;
			end
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (lat_done[k]) begin
					res_r[lat_slot_r[k]] <= CONV_DATA;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flag placement and DMA trigger
	assign lat_src  = (lat_done[0] && (lat_slot_r[0] == int_src_r)) ||
	                  (lat_done[1] && (lat_slot_r[1] == int_src_r));
	assign cint_set = ieoc_r ? (eoc_done && (eoc_slot_r == int_src_r))
	                         : tmr_if[1].done;
	assign dma_now  = dma_sel_r ? lat_src : cint_set;

	// Sticky status; a new event beats a clear in the same cycle
	always_comb begin
		stat_nxt = stat_r;
		if (stat_wr) begin
			stat_nxt = stat_r & ~REG_WDATA[1:0];
		end
		stat_nxt[`ACT_ST_CINT] = stat_nxt[`ACT_ST_CINT] | cint_set;
		stat_nxt[`ACT_ST_LAT]  = stat_nxt[`ACT_ST_LAT] | (|lat_done);
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			stat_r <= `ACT_STAT_RST;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// Registered outputs
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			eoc_pulse_r <= 1'b0;
			int_evt_r   <= 1'b0;
			dma_r       <= 1'b0;
			irq_r       <= 1'b0;
			busy_r      <= 1'b0;
			slot_out_r  <= '0;
		end else begin
			eoc_pulse_r <= eoc_done;
			int_evt_r   <= cint_set;
			dma_r       <= dma_now;
			irq_r       <= |(stat_r & mask_r);
			busy_r      <= (st_r != ACT_IDLE) || (|pend_r);
			slot_out_r  <= cur_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (is_win) begin
			rd_mux = 32'(win_r[rslot]);
		end else if (is_res) begin
			rd_mux = {20'h00000, rd_res_w};
		end else begin
			unique case (REG_ADDR)
				`ACT_OFF_CTL1:   rd_mux = {29'h0, scr_r, dma_sel_r, ieoc_r};
				`ACT_OFF_CTL2:   rd_mux = {28'h0, presc_r};
				`ACT_OFF_INTDLY: rd_mux = 32'(int_off_r);
				`ACT_OFF_STAT:   rd_mux = {30'h0, stat_r};
				`ACT_OFF_MASK:   rd_mux = {30'h0, mask_r};
				`ACT_OFF_FORCE:  rd_mux = {16'h0, pend_r};
				`ACT_OFF_STATUS: rd_mux = {24'h0, cur_r, 2'h0, st_r};
				`ACT_OFF_INTSEL: rd_mux = {28'h0, int_src_r};
				default:         rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= REG_RD ? rd_mux : 32'h0000_0000;
		end
	end

	assign REG_RDATA = rdata_r;
	assign SH_OPEN   = sh_open_r;
	assign EOC_PULSE = eoc_pulse_r;
	assign INT_EVENT = int_evt_r;
	assign DMA_TRIG  = dma_r;
	assign CONV_IRQ  = irq_r;
	assign BUSY      = busy_r;
	assign CUR_SLOT  = slot_out_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [WIN_W:0]   sh_seen_r;
	logic [WIN_W-1:0] cur_win_r;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			sh_seen_r <= '0;
			cur_win_r <= '0;
		end else begin
			sh_seen_r <= sh_open_r ? sh_seen_r + 1'b1 : '0;
			if (start_now) begin
				cur_win_r <= win_r[pick_slot];
			end
		end
	end

	a_sh_window_len: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		$fell(sh_open_r) |-> sh_seen_r == ({1'b0, cur_win_r} + 1'b1))
		else $error("sample window length differs from count plus one");

	a_slot_own_win: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		start_now && !REG_WR |=> sh_cnt_r == win_r[cur_r])
		else $error("window not loaded from the chosen slot");

	a_result_old_val: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		REG_RD && is_res |=> REG_RDATA == {20'h00000, $past(rd_res_w)})
		else $error("result read does not return the stored value");

	a_next_win_start: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(st_r == ACT_WAIT_EOC) && eoc_done && pick_ok |=> SH_OPEN)
		else $error("next window did not open at end of conversion");

	a_flag_at_eoc: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		ieoc_r && eoc_done && (eoc_slot_r == int_src_r) |=> INT_EVENT && EOC_PULSE)
		else $error("flag not aligned with end of conversion");

	a_flag_early: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		win_end && !ieoc_r && (int_off_r == '0) && (cur_r == int_src_r) ##1 !ieoc_r
		|=> INT_EVENT)
		else $error("early flag not one cycle after window end");

	a_flag_delayed: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		win_end && !ieoc_r && (int_off_r == DLY_W'(2)) && (cur_r == int_src_r)
		|-> ##1 (!ieoc_r && !INT_EVENT)[*3] ##1 INT_EVENT)
		else $error("delayed flag not postponed by two cycles");

	a_dma_at_latch: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		dma_sel_r && lat_src |=> DMA_TRIG && stat_r[`ACT_ST_LAT])
		else $error("DMA trigger missed the latch time");

	a_eoc_code15: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		win_end && !scr_r && (presc_r == 4'hf) |-> ##129 EOC_PULSE)
		else $error("end of conversion not 128 cycles after window");

	a_eoc_scr_code0: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		win_end && scr_r && (presc_r == 4'h0) |-> ##15 EOC_PULSE)
		else $error("end of conversion not 14 cycles with cap reset");

	a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		stat_r[`ACT_ST_CINT] && !(stat_wr && REG_WDATA[`ACT_ST_CINT]) |=> stat_r[`ACT_ST_CINT])
		else $error("conversion flag dropped without a clear");
endmodule

// ---- verif/act_far_model.sv ----
// Purpose: far side of the conversion timing block, the interrupt
//          expansion path and the DMA reader, timing every event
// Assumes: all signals on the system clock, outputs of the block registered
// Notes:   delays count cycles after the first cycle with the window closed
`timescale 1ns/100ps
module act_far_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sh_open,
	input  wire logic        eoc_pulse,
	input  wire logic        int_event,
	input  wire logic        dma_trig,
	output logic [15:0]      win_len,
	output logic [15:0]      eoc_dly,
	output logic [15:0]      int_dly,
	output logic [15:0]      dma_dly,
	output logic [15:0]      start_gap,
	output logic [15:0]      event_cnt
);
	logic [15:0] open_cnt_r;
	logic [15:0] since_r;
	logic        was_open_r;
	logic        fall;
	logic [15:0] k_now;

	////////////////////////////////////////////////////////////////////////////////
	// Cycle index relative to the last window end
	assign fall  = was_open_r && !sh_open;
	assign k_now = fall ? 16'h0 : since_r + 16'h1;

	// The eoc, flag and DMA timestamps reset to all ones at each window end so a missing event shows
	always_ff @(posedge clk) begin
		if (rst) begin
			{open_cnt_r, since_r, win_len, eoc_dly, int_dly} <= '0;
			{dma_dly, start_gap, event_cnt} <= '0;
			was_open_r <= 1'b0;
		end else begin
			was_open_r <= sh_open;
			since_r    <= k_now;
			if (sh_open)
				open_cnt_r <= open_cnt_r + 16'h1;
			if (fall) begin
				win_len    <= open_cnt_r;
				open_cnt_r <= 16'h0;
				eoc_dly    <= 16'hffff;
				int_dly    <= 16'hffff;
				dma_dly    <= 16'hffff;
			end
			if (sh_open && !was_open_r)
				start_gap <= k_now;
			if (eoc_pulse)
				eoc_dly <= k_now;
			// The interrupt expansion takes each flag event as one request
			if (int_event) begin
				int_dly   <= k_now;
				event_cnt <= event_cnt + 16'h1;
			end
			// A DMA read is launched on every trigger
			if (dma_trig)
				dma_dly <= k_now;
		end
	end
endmodule

// ---- verif/act_conv_timing_tb.sv ----
// Purpose: self-checking bench of the conversion timing block
// Assumes: seed 22, one clock at 40 MHz, registers on the strobe port
// Notes:   waits after each conversion are long enough for the slowest latch
`timescale 1ns/100ps
module act_conv_timing_tb;
	import act_pkg::*;
	logic        clk;
	logic        rst;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [11:0] conv;
	logic        sh_open, eoc_p, int_ev, dma, irq, busy;
	act_slot_t   cur_slot;
	logic [15:0] win_len, eoc_dly, int_dly, dma_dly, start_gap, event_cnt;
	logic [11:0] res_exp [16];
	// Fixed corners: code 0 both cap options, the code 3 latch quirk, code 15 both
	logic [3:0]  codes [8] = '{4'h0, 4'h0, 4'h2, 4'h3, 4'h3, 4'h9, 4'hf, 4'hf};
	logic        caps [8]  = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
	int          err_total = 0;
	int          compares  = 0;
	int          cyc       = 0;

	act_conv_timing u_dut (.CORE_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CONV_DATA(conv), .SH_OPEN(sh_open),
		.EOC_PULSE(eoc_p), .INT_EVENT(int_ev), .DMA_TRIG(dma), .CONV_IRQ(irq), .BUSY(busy),
		.CUR_SLOT(cur_slot));
	act_far_model u_far (.clk(clk), .rst(rst), .sh_open(sh_open), .eoc_pulse(eoc_p),
		.int_event(int_ev), .dma_trig(dma), .win_len(win_len), .eoc_dly(eoc_dly),
		.int_dly(int_dly), .dma_dly(dma_dly), .start_gap(start_gap), .event_cnt(event_cnt));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare, bus and verdict tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just then
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 1000) begin
			@(posedge clk);
			k++;
		end
		chk(busy, 1'b0);
		// Late events (flag offset, latch) come after the sequencer idles
		repeat (150) @(posedge clk);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Expected delays from divider code and cap reset option
	function automatic logic [15:0] eoc_of(input logic [3:0] c, input logic cap);
		logic [15:0] b;
		b = cap ? 16'he : 16'hf;
		if (c < 4'h2)
			return b;
		return (b * (16'(c) + 16'h2) + 16'h1) / 16'h2;
	endfunction
	function automatic logic [15:0] lat_of(input logic [3:0] c, input logic cap);
		return eoc_of(c, cap) + ((c == 4'h3 && !cap) ? 16'h8 : 16'h5);
	endfunction

	// One conversion of slot s; ctl is {cap reset, dma select, flag at end}
	task automatic run_conv(input logic [3:0] s, input logic [8:0] n, input logic [3:0] c,
		input logic [2:0] ctl, input logic [7:0] off);
		logic [15:0] e, l, t, ev0;
		logic [31:0] d;
		e = eoc_of(c, ctl[2]);
		l = lat_of(c, ctl[2]);
		t = ctl[0] ? e : 16'h1 + {8'h0, off};
		wr_reg(8'h00, {29'h0, ctl});
		wr_reg(8'h04, {28'h0, c});
		wr_reg(8'h08, {24'h0, off});
		wr_reg(8'h1c, {28'h0, s});
		wr_reg(8'h40 + {2'h0, s, 2'h0}, {23'h0, n});
		wr_reg(8'h40 + {2'h0, s ^ 4'h1, 2'h0}, {23'h0, n} + 32'h5);
		ev0 = event_cnt;
		conv <= 12'($urandom);
		wr_reg(8'h14, 32'h1 << s);
		rd_chk(8'h80 + {2'h0, s, 2'h0}, {20'h0, res_exp[s]});
		res_exp[s] = conv;
		wait_idle();
		chk(win_len, {7'h0, n} + 16'h1);
		chk(eoc_dly, e);
		chk(int_dly, t);
		chk(dma_dly, ctl[1] ? l : t);
		chk(event_cnt, ev0 + 16'h1);
		chk(cur_slot, s);
		rd_chk(8'h80 + {2'h0, s, 2'h0}, {20'h0, res_exp[s]});
		rd_reg(8'h0c, d);
		chk(d[0], 1'b1);
		chk(irq, 1'b1);
		wr_reg(8'h0c, 32'h3);
		rd_reg(8'h0c, d);
		chk(d[0], 1'b0);
		chk(irq, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset values, timing tables, random mix, back to back
	initial begin
		logic [31:0] d;
		rst   = 1'b1;
		addr  = 8'h0;
		wdata = 32'h0;
		wr    = 1'b0;
		rd    = 1'b0;
		conv  = 12'h0;
		foreach (res_exp[i])
			res_exp[i] = 12'h0;
		void'($urandom(22));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h0c, 32'h0);
		rd_chk(8'h04, 32'h0);
		rd_chk(8'hfc, 32'h0);
		wr_reg(8'h10, 32'h1);
		for (int i = 0; i < 14; i++) begin
			if (i < 8)
				run_conv(4'(i), 9'(i * 3), codes[i], {caps[i], 2'(i)}, i[0] ? 8'h0 : 8'(i * i / 2));
			else
				run_conv(4'($urandom), 9'($urandom % 41), 4'($urandom), 3'($urandom),
					8'($urandom % 41));
		end
		// Two pending slots, neither the flag source: second window follows at eoc
		wr_reg(8'h00, 32'h0);
		wr_reg(8'h04, 32'h0);
		wr_reg(8'h08, 32'h0);
		wr_reg(8'h48, 32'ha);
		wr_reg(8'h4c, 32'hc);
		wr_reg(8'h1c, 32'h1);
		conv <= 12'($urandom);
		wr_reg(8'h14, 32'hc);
		wait_idle();
		chk(start_gap, 16'hf);
		chk(int_dly, 16'hffff);
		rd_chk(8'h88, {20'h0, conv});
		rd_chk(8'h8c, {20'h0, conv});
		// Masked flag stays sticky but keeps the interrupt line low
		wr_reg(8'h10, 32'h0);
		wr_reg(8'h1c, 32'h0);
		wr_reg(8'h14, 32'h1);
		wait_idle();
		rd_reg(8'h0c, d);
		chk(d[0], 1'b1);
		chk(irq, 1'b0);
		print_verdict();
	end
endmodule
